// ==== design/sric_map.vh ====
`ifndef SRIC_MAP_VH
`define SRIC_MAP_VH

// Register byte offsets
`define SRIC_CTRL_OFS 8'h00
`define SRIC_STAT_OFS 8'h04
`define SRIC_OUTS_OFS 8'h08

// Control fields
`define SRIC_CTRL_WDEN 0
`define SRIC_CTRL_SWRST 1
`define SRIC_CTRL_RST 1'h1

// Status fields
`define SRIC_STAT_LOCK 0
`define SRIC_STAT_INRST 1
`define SRIC_STAT_FAULT 2
`define SRIC_STAT_CAUSE_LO 4
`define SRIC_STAT_CAUSE_HI 5
`define SRIC_STAT_HEAVY 6

// Reset cause codes
`define SRIC_CAUSE_POR 2'h0
`define SRIC_CAUSE_CMD 2'h1
`define SRIC_CAUSE_LOGIC 2'h2
`define SRIC_CAUSE_EXT 2'h3

// Output register reset value
`define SRIC_OUT_RST 4'hF

// Timing figures
`define SRIC_CLK_MHZ 125
`define SRIC_POR_PULSE_NS 5000
`define SRIC_STROBE_NS 1000
`define SRIC_EXT_REJECT_US 35
`define SRIC_EXT_EXEC_US 40
`define SRIC_INIT_SW_US 2000
`define SRIC_INIT_POR_US 30000
`define SRIC_INIT_HEAVY_MS 1000

`endif

// ==== design/sric_sync.v ====
`timescale 1ns/10ps
module sric_sync #(
    parameter W = 2,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// ==== design/sric_timer.v ====
`timescale 1ns/10ps
module sric_timer #(
    parameter W = 27
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire abort_i,
    input wire [W-1:0] load_i,
    output wire busy_o,
    output wire done_o,
    output wire [W-1:0] count_o
);
    reg [W-1:0] cnt_r;
    reg busy_r;
    reg done_r;

    // Done fires load_i edges after the start edge; start wins over abort
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {W{1'b0}};
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start_i) begin
                cnt_r <= load_i;
                busy_r <= 1'b1;
            end else if (abort_i) begin
                busy_r <= 1'b0;
                cnt_r <= {W{1'b0}};
            end else if (busy_r) begin
                if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    cnt_r <= {W{1'b0}};
                end else begin
                    cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;
    assign count_o = cnt_r;
endmodule

// ==== design/sric_top.v ====
// Summary of operation
// - Every reset loads data and parameter outputs with 0xF, drivers off.
// - Non power-on resets pulse reset and parameter strobes together.
// - Any reset sets the exchange lock flag.
// - Command or pin reset initialisation ends within 2 ms.
// - Power-on initialisation ends within 30 ms, light supply load.
// - Power-on initialisation ends within 1000 ms, heavy supply load.
// - Internal power-on reset pulse lasts 4 to 6 us.
// - Reset on slave or broadcast command, enabled watchdog, illegal state.
// - Addressing channel in AC current mode diverts reset commands.
// - Pin reset works in every operating mode.
// - Pin low for 35 us or less starts no reset.
// - Output drivers go high impedance within 44 us of pin falling.
// - Initialisation after pin reset ends within 2 ms.
// - Pin reset fires on timer expiry, regardless of pin level then.
// - Slave mode flags serious fault if pin still low after init.
// - While locked, data port is refused and no-exchange is shown.
`timescale 1ns/10ps
`include "sric_map.vh"
module sric_top #(
    parameter [26:0] INIT_SW_CYC = `SRIC_INIT_SW_US * `SRIC_CLK_MHZ,
    parameter [26:0] INIT_POR_CYC = `SRIC_INIT_POR_US * `SRIC_CLK_MHZ,
    parameter [26:0] INIT_HEAVY_CYC =
        `SRIC_INIT_HEAVY_MS * 1000 * `SRIC_CLK_MHZ,
    parameter [26:0] EXT_REJECT_CYC = `SRIC_EXT_REJECT_US * `SRIC_CLK_MHZ,
    parameter [26:0] EXT_EXEC_CYC = `SRIC_EXT_EXEC_US * `SRIC_CLK_MHZ
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire reset_slave_cmd_i,
    input wire broadcast_reset_cmd_i,
    input wire watchdog_expired_i,
    input wire illegal_state_i,
    input wire addr_chan_active_i,
    input wire ac_current_mode_i,
    input wire slave_mode_i,
    input wire heavy_load_i,
    input wire param_write_ok_i,
    input wire [3:0] param_value_i,
    input wire data_write_i,
    input wire [3:0] data_value_i,
    input wire strobe_rst_i,
    output wire strobe_rst_o,
    output wire strobe_rst_oe_o,
    output wire param_strobe_o,
    output wire [3:0] data_out_pins_o,
    output wire data_out_oe_o,
    output wire [3:0] param_out_pins_o,
    output wire param_out_oe_o,
    output wire logic_reset_o,
    output wire init_done_o,
    output wire xchg_lock_o,
    output wire data_port_en_o,
    output wire serious_fault_o,
    output wire ac_reset_cmd_o
);
    localparam [1:0] ST_POR = 2'd0;
    localparam [1:0] ST_INIT = 2'd1;
    localparam [1:0] ST_RUN = 2'd2;

    // 5 us sits in the middle of the allowed pulse width
    localparam [26:0] POR_CYC =
        (`SRIC_POR_PULSE_NS * `SRIC_CLK_MHZ) / 1000;
    localparam [26:0] STROBE_CYC =
        (`SRIC_STROBE_NS * `SRIC_CLK_MHZ) / 1000;
    localparam [26:0] REJECT_LEFT = EXT_EXEC_CYC - EXT_REJECT_CYC;

    wire [1:0] sync_w;
    wire [26:0] ext_cnt;
    wire [26:0] seq_load;
    wire pin_lvl, seq_busy, seq_done, ext_busy, ext_done, strb_busy;
    wire ac_divert, cmd_rst, wd_rst, ill_rst, any_rst, trig, go_init;
    wire seq_start, ext_fall, ext_abort, apb_acc, apb_wr, in_run;
    wire lock_nxt;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] cause_r;
    reg [3:0] data_out_r;
    reg [3:0] param_out_r;
    reg [31:0] prdata_r;
    reg [31:0] rd_mux;
    reg por_start_r, heavy_r, pin_d_r, data_oe_r, param_oe_r, lock_r;
    reg flt_chk_r, fault_r, lrst_r, done_r, ac_cmd_r, wd_en_r, sw_rst_r;
    reg pready_r, pslverr_r, rd_err, port_en_r;

    sric_sync #(
        .W(2),
        .RST_VAL(2'b01)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({heavy_load_i, strobe_rst_i}),
        .sync_o(sync_w)
    );

    assign pin_lvl = sync_w[0];
    assign in_run = (state_r == ST_RUN);

    // Merged reset request from every source but power-on
    assign ac_divert = addr_chan_active_i & ac_current_mode_i;
    assign cmd_rst = (reset_slave_cmd_i | broadcast_reset_cmd_i)
                     & ~ac_divert;
    assign wd_rst = watchdog_expired_i & wd_en_r;
    assign ill_rst = illegal_state_i | (state_r == 2'd3);
    assign any_rst = cmd_rst | wd_rst | ill_rst | sw_rst_r | ext_done;
    assign trig = any_rst & (state_r != ST_POR);
    assign lock_nxt = trig | (lock_r & ~(in_run & param_write_ok_i));

    // Our own strobe drive is masked so it never looks like a pin reset
    assign ext_fall = pin_d_r & ~pin_lvl & ~strb_busy & ~ext_busy;
    // Release before the reject window ends cancels the pin reset
    assign ext_abort = pin_lvl & (ext_cnt >= REJECT_LEFT);

    sric_timer #(
        .W(27)
    ) u_ext (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(ext_fall),
        .abort_i(ext_abort),
        .load_i(EXT_EXEC_CYC),
        .busy_o(ext_busy),
        .done_o(ext_done),
        .count_o(ext_cnt)
    );

    assign go_init = trig | (state_r == ST_POR && seq_done);
    assign seq_start = por_start_r | go_init;
    assign seq_load = por_start_r ? POR_CYC :
                      trig ? INIT_SW_CYC :
                      sync_w[1] ? INIT_HEAVY_CYC :
                      INIT_POR_CYC;

    sric_timer #(
        .W(27)
    ) u_seq (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(seq_start),
        .abort_i(1'b0),
        .load_i(seq_load),
        .busy_o(seq_busy),
        .done_o(seq_done),
        .count_o()
    );

    sric_timer #(
        .W(27)
    ) u_strb (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(trig),
        .abort_i(1'b0),
        .load_i(STROBE_CYC),
        .busy_o(strb_busy),
        .done_o(),
        .count_o()
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_POR: begin
                if (seq_done)
                    state_nxt = ST_INIT;
            end
            ST_INIT: begin
                if (trig)
                    state_nxt = ST_INIT;
                else if (seq_done && !seq_busy)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (trig)
                    state_nxt = ST_INIT;
            end
            default: begin
                state_nxt = ST_INIT;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_POR;
            por_start_r <= 1'b1;
            heavy_r <= 1'b0;
            pin_d_r <= 1'b1;
            lrst_r <= 1'b1;
            done_r <= 1'b0;
            ac_cmd_r <= 1'b0;
            port_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            por_start_r <= 1'b0;
            pin_d_r <= pin_lvl;
            // Load strap is caught when the power-on pulse ends
            if (state_r == ST_POR && seq_done)
                heavy_r <= sync_w[1];
            lrst_r <= (state_nxt != ST_RUN);
            done_r <= (state_r == ST_INIT) && (state_nxt == ST_RUN);
            port_en_r <= ~lock_nxt & (state_nxt == ST_RUN);
            ac_cmd_r <= ac_divert & in_run
                        & (reset_slave_cmd_i | broadcast_reset_cmd_i);
        end
    end

    // Output registers, lock and cause
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_out_r <= `SRIC_OUT_RST;
            data_oe_r <= 1'b0;
            param_out_r <= `SRIC_OUT_RST;
            param_oe_r <= 1'b0;
            lock_r <= 1'b1;
            cause_r <= `SRIC_CAUSE_POR;
        end else if (trig) begin
            data_out_r <= `SRIC_OUT_RST;
            data_oe_r <= 1'b0;
            param_out_r <= `SRIC_OUT_RST;
            param_oe_r <= 1'b0;
            lock_r <= 1'b1;
            if (ext_done)
                cause_r <= `SRIC_CAUSE_EXT;
            else if (cmd_rst)
                cause_r <= `SRIC_CAUSE_CMD;
            else
                cause_r <= `SRIC_CAUSE_LOGIC;
        end else if (in_run) begin
            if (param_write_ok_i) begin
                param_out_r <= param_value_i;
                param_oe_r <= 1'b1;
                lock_r <= 1'b0;
            end
            // Data writes are dropped while the lock stands
            if (data_write_i && !lock_r) begin
                data_out_r <= data_value_i;
                data_oe_r <= 1'b1;
            end
        end
    end

    // Serious fault: set wins over both clears
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flt_chk_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            if (trig)
                flt_chk_r <= ext_done;
            else if (seq_done)
                flt_chk_r <= 1'b0;
            if (flt_chk_r && seq_done && !trig && slave_mode_i && !pin_lvl)
                fault_r <= 1'b1;
            else if (pin_lvl ||
                     (apb_wr && paddr_i == `SRIC_STAT_OFS &&
                      pwdata_i[`SRIC_STAT_FAULT]))
                fault_r <= 1'b0;
        end
    end

    // APB slave: one wait state, write acts at the pready edge
    assign apb_acc = psel_i & penable_i & pready_r;
    assign apb_wr = apb_acc & pwrite_i;

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr_i)
            `SRIC_CTRL_OFS: rd_mux[`SRIC_CTRL_WDEN] = wd_en_r;
            `SRIC_STAT_OFS: begin
                rd_mux[`SRIC_STAT_LOCK] = lock_r;
                rd_mux[`SRIC_STAT_INRST] = lrst_r;
                rd_mux[`SRIC_STAT_FAULT] = fault_r;
                rd_mux[`SRIC_STAT_CAUSE_HI:`SRIC_STAT_CAUSE_LO] = cause_r;
                rd_mux[`SRIC_STAT_HEAVY] = heavy_r;
            end
            `SRIC_OUTS_OFS: begin
                rd_mux[3:0] = data_out_r;
                rd_mux[7:4] = param_out_r;
                rd_mux[8] = data_oe_r;
                rd_mux[9] = param_oe_r;
            end
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            wd_en_r <= `SRIC_CTRL_RST;
            sw_rst_r <= 1'b0;
        end else begin
            pready_r <= psel_i & penable_i & ~pready_r;
            if (psel_i && penable_i && !pready_r) begin
                pslverr_r <= rd_err;
                prdata_r <= (pwrite_i || rd_err) ? 32'h0000_0000 : rd_mux;
            end
            sw_rst_r <= 1'b0;
            if (apb_wr && paddr_i == `SRIC_CTRL_OFS) begin
                wd_en_r <= pwdata_i[`SRIC_CTRL_WDEN];
                sw_rst_r <= pwdata_i[`SRIC_CTRL_SWRST];
            end
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign strobe_rst_o = strb_busy;
    assign strobe_rst_oe_o = strb_busy;
    assign param_strobe_o = strb_busy;
    assign data_out_pins_o = data_out_r;
    assign data_out_oe_o = data_oe_r;
    assign param_out_pins_o = param_out_r;
    assign param_out_oe_o = param_oe_r;
    assign logic_reset_o = lrst_r;
    assign init_done_o = done_r;
    assign xchg_lock_o = lock_r;
    assign data_port_en_o = port_en_r;
    assign serious_fault_o = fault_r;
    assign ac_reset_cmd_o = ac_cmd_r;
endmodule

// ==== testbench/sric_checker.sv ====
`timescale 1ns/10ps
module sric_checker #(
    parameter int INIT_SW_CYC = 200,
    parameter int EXT_EXEC_CYC = 40
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire reset_slave_cmd_i,
    input wire broadcast_reset_cmd_i,
    input wire addr_chan_active_i,
    input wire ac_current_mode_i,
    input wire slave_mode_i,
    input wire param_write_ok_i,
    input wire [3:0] param_value_i,
    input wire data_write_i,
    input wire strobe_rst_i,
    input wire strobe_rst_o,
    input wire strobe_rst_oe_o,
    input wire param_strobe_o,
    input wire [3:0] data_out_pins_o,
    input wire data_out_oe_o,
    input wire [3:0] param_out_pins_o,
    input wire param_out_oe_o,
    input wire logic_reset_o,
    input wire init_done_o,
    input wire xchg_lock_o,
    input wire serious_fault_o
);
    localparam int SW_MAX = INIT_SW_CYC + 2;
    localparam int LOW_LIM = EXT_EXEC_CYC + 8;
    logic [7:0] low_cnt_r;
    logic [9:0] up_cnt_r;
    wire cmd = reset_slave_cmd_i | broadcast_reset_cmd_i;
    wire divert = addr_chan_active_i & ac_current_mode_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Saturates so a stuck-low pin never wraps back into range
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            low_cnt_r <= 8'h00;
        else if (strobe_rst_i)
            low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hFF)
            low_cnt_r <= low_cnt_r + 8'h01;
    end
    // Cycles since release; sources cannot fire while power-on runs
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            up_cnt_r <= 10'h000;
        else if (up_cnt_r != 10'h3FF)
            up_cnt_r <= up_cnt_r + 10'h001;
    end
    property p_cmd_reset;
        cmd && !divert && !logic_reset_o |=> logic_reset_o && xchg_lock_o
            && data_out_pins_o == 4'hF && param_out_pins_o == 4'hF
            && !data_out_oe_o && !param_out_oe_o;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset)
        else $error("command reset outputs wrong");
    property p_strobe;
        cmd && !divert && !logic_reset_o
            |=> (param_strobe_o && strobe_rst_oe_o && strobe_rst_o) [*8];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobes missing");
    property p_por_quiet;
        up_cnt_r < 10'h260 |-> !param_strobe_o && !strobe_rst_oe_o;
    endproperty
    a_por_quiet: assert property (p_por_quiet)
        else $error("strobe at power on");
    property p_init_sw;
        $rose(logic_reset_o) |-> ##[1:SW_MAX] !logic_reset_o;
    endproperty
    a_init_sw: assert property (p_init_sw)
        else $error("init too long");
    property p_done;
        $fell(logic_reset_o) |-> init_done_o ##1 !init_done_o;
    endproperty
    a_done: assert property (p_done)
        else $error("init done pulse wrong");
    property p_divert;
        reset_slave_cmd_i && divert && !logic_reset_o |=> !logic_reset_o;
    endproperty
    a_divert: assert property (p_divert)
        else $error("diverted command reset");
    property p_pin;
        low_cnt_r == LOW_LIM |-> logic_reset_o && !data_out_oe_o
            && !param_out_oe_o;
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin reset late");
    property p_fault;
        $rose(serious_fault_o) |-> slave_mode_i && low_cnt_r > LOW_LIM;
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault without stuck pin");
    property p_unlock;
        param_write_ok_i && !logic_reset_o && !cmd |=> !xchg_lock_o
            && param_out_oe_o && param_out_pins_o == $past(param_value_i);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("parameter write not taken");
    property p_refuse;
        xchg_lock_o && data_write_i |=> $stable(data_out_pins_o)
            && !data_out_oe_o;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("locked data write taken");
endmodule

bind sric_top sric_checker #(.INIT_SW_CYC(INIT_SW_CYC),
    .EXT_EXEC_CYC(EXT_EXEC_CYC)) u_chk (.sys_clk_i, .rst_n_i,
    .reset_slave_cmd_i, .broadcast_reset_cmd_i, .addr_chan_active_i,
    .ac_current_mode_i, .slave_mode_i, .param_write_ok_i, .param_value_i,
    .data_write_i, .strobe_rst_i, .strobe_rst_o, .strobe_rst_oe_o,
    .param_strobe_o, .data_out_pins_o, .data_out_oe_o, .param_out_pins_o,
    .param_out_oe_o, .logic_reset_o, .init_done_o, .xchg_lock_o,
    .serious_fault_o);

// ==== testbench/sric_partner.sv ====
`timescale 1ns/10ps
module sric_partner (
    input wire sys_clk_i,
    output logic reset_slave_cmd_o,
    output logic broadcast_reset_cmd_o,
    output logic param_write_ok_o,
    output logic [3:0] param_value_o,
    output logic data_write_o,
    output logic [3:0] data_value_o,
    output logic pull_low_o
);
    bit primed = 1'b0;
    initial begin
        reset_slave_cmd_o = 1'b0;
        broadcast_reset_cmd_o = 1'b0;
        param_write_ok_o = 1'b0;
        param_value_o = 4'h0;
        data_write_o = 1'b0;
        data_value_o = 4'h0;
        pull_low_o = 1'b0;
    end
    task automatic cmd(input int kind);
        @(posedge sys_clk_i);
        if (kind == 0)
            reset_slave_cmd_o <= 1'b1;
        else
            broadcast_reset_cmd_o <= 1'b1;
        primed = 1'b0;
        @(posedge sys_clk_i);
        reset_slave_cmd_o <= 1'b0;
        broadcast_reset_cmd_o <= 1'b0;
    endtask
    task automatic param_wr(input logic [3:0] v);
        @(posedge sys_clk_i);
        param_write_ok_o <= 1'b1;
        param_value_o <= v;
        primed = 1'b1;
        @(posedge sys_clk_i);
        param_write_ok_o <= 1'b0;
        // Released lines show junk, not the last value
        param_value_o <= ~v;
    endtask
    // A rude master skips the parameter write on purpose
    task automatic data_wr(input logic [3:0] v, input bit rude);
        if (!primed && !rude)
            param_wr(4'h0);
        @(posedge sys_clk_i);
        data_write_o <= 1'b1;
        data_value_o <= v;
        @(posedge sys_clk_i);
        data_write_o <= 1'b0;
        data_value_o <= ~v;
    endtask
    task automatic pin_low(input int n);
        @(posedge sys_clk_i);
        pull_low_o <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        pull_low_o <= 1'b0;
    endtask
endmodule

// ==== testbench/sric_top_tb.sv ====
`timescale 1ns/10ps
module sric_top_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic watchdog_expired_i = 1'b0, illegal_state_i = 1'b0;
    logic addr_chan_active_i, ac_current_mode_i, slave_mode_i, heavy_load_i;
    wire reset_slave_cmd_i, broadcast_reset_cmd_i, param_write_ok_i;
    wire data_write_i, pull_low, pready_o, pslverr_o, strobe_rst_o;
    wire [3:0] param_value_i, data_value_i, data_out_pins_o;
    wire [3:0] param_out_pins_o;
    wire [31:0] prdata_o;
    wire strobe_rst_oe_o, param_strobe_o, data_out_oe_o, param_out_oe_o;
    wire logic_reset_o, init_done_o, xchg_lock_o, data_port_en_o;
    wire serious_fault_o, ac_reset_cmd_o;
    // A reset switch pulling low beats the strobe; pull-up otherwise
    wire strobe_rst_i = pull_low ? 1'b0 :
        strobe_rst_oe_o ? strobe_rst_o : 1'b1;
    wire [9:0] outs = {data_out_oe_o, param_out_oe_o, data_out_pins_o,
        param_out_pins_o};
    int miscompares = 0, n_checks = 0, t;
    logic [31:0] rd;
    logic err, seen;
    always #4 sys_clk_i = ~sys_clk_i;
    sric_top #(.INIT_SW_CYC(27'h0C8), .INIT_POR_CYC(27'h12C),
        .INIT_HEAVY_CYC(27'h190), .EXT_REJECT_CYC(27'h01E),
        .EXT_EXEC_CYC(27'h028)) u_dut (.sys_clk_i, .rst_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .reset_slave_cmd_i, .broadcast_reset_cmd_i,
        .watchdog_expired_i, .illegal_state_i, .addr_chan_active_i,
        .ac_current_mode_i, .slave_mode_i, .heavy_load_i, .param_write_ok_i,
        .param_value_i, .data_write_i, .data_value_i, .strobe_rst_i,
        .strobe_rst_o, .strobe_rst_oe_o, .param_strobe_o, .data_out_pins_o,
        .data_out_oe_o, .param_out_pins_o, .param_out_oe_o, .logic_reset_o,
        .init_done_o, .xchg_lock_o, .data_port_en_o, .serious_fault_o,
        .ac_reset_cmd_o);
    sric_partner u_far (.sys_clk_i, .reset_slave_cmd_o(reset_slave_cmd_i),
        .broadcast_reset_cmd_o(broadcast_reset_cmd_i),
        .param_write_ok_o(param_write_ok_i), .param_value_o(param_value_i),
        .data_write_o(data_write_i), .data_value_o(data_value_i),
        .pull_low_o(pull_low));
    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo;
        miscompares++;
        print_verdict;
    endtask
    task automatic set_mode(input logic [3:0] m);
        {addr_chan_active_i, ac_current_mode_i, slave_mode_i,
            heavy_load_i} <= m;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        t = 0;
        do begin
            @(posedge sys_clk_i);
            t++;
            if (t > 20)
                tmo;
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_run;
        t = 0;
        while (logic_reset_o !== 1'b0) begin
            @(posedge sys_clk_i);
            t++;
            if (t > 3000)
                tmo;
        end
    endtask
    task automatic fire(input int k);
        if (k < 2)
            u_far.cmd(k);
        else if (k == 4) begin
            apb(1'b1, 8'h00, 32'h0000_0003);
            @(posedge sys_clk_i);
        end else begin
            @(posedge sys_clk_i);
            watchdog_expired_i <= (k == 2);
            illegal_state_i <= (k == 3);
            @(posedge sys_clk_i);
            watchdog_expired_i <= 1'b0;
            illegal_state_i <= 1'b0;
        end
    endtask
    initial begin
        set_mode(4'h0);
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        wait_run;
        chk("por_len", t >= 925 && t <= 932, 32'h0000_0001);
        chk("outs", outs, 32'h0000_00FF);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("status", rd, 32'h0000_0001);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        u_far.data_wr(4'h5, 1'b1);
        @(posedge sys_clk_i);
        chk("locked", {data_port_en_o, outs}, 32'h0000_00FF);
        for (int k = 0; k < 5; k++) begin
            u_far.param_wr(4'hA);
            u_far.data_wr(4'h5, 1'b0);
            @(posedge sys_clk_i);
            chk("run", {data_port_en_o, xchg_lock_o, outs},
                32'h0000_0B5A);
            fire(k);
            @(posedge sys_clk_i);
            chk("strb", {param_strobe_o, strobe_rst_oe_o}, 32'h3);
            chk("rst", {xchg_lock_o, outs}, 32'h0000_04FF);
            wait_run;
            chk("init", t <= 202, 32'h0000_0001);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk("cause", rd[5:4], (k < 2) ? 32'h1 : 32'h2);
        end
        apb(1'b1, 8'h00, 32'h0000_0000);
        fire(2);
        repeat (3) @(posedge sys_clk_i);
        chk("wd_off", logic_reset_o, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_0001);
        set_mode(4'hC);
        u_far.cmd(0);
        seen = 1'b0;
        repeat (4) begin
            @(posedge sys_clk_i);
            seen = seen | ac_reset_cmd_o;
        end
        chk("divert", {seen, logic_reset_o}, 32'h0000_0002);
        set_mode(4'h0);
        u_far.pin_low(25);
        repeat (60) @(posedge sys_clk_i);
        chk("short_pin", logic_reset_o, 32'h0000_0000);
        u_far.pin_low(60);
        wait_run;
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("pin_rst", rd, 32'h0000_0031);
        apb(1'b1, 8'h08, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk("outs_ro", {err, rd[30:0]}, 32'h0000_00FF);
        set_mode(4'h2);
        u_far.pin_low(400);
        chk("fault", {logic_reset_o, serious_fault_o}, 32'h1);
        repeat (6) @(posedge sys_clk_i);
        chk("fault_clr", serious_fault_o, 32'h0000_0000);
        set_mode(4'h3);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        wait_run;
        chk("heavy_len", t >= 1025 && t <= 1032, 32'h1);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("heavy_st", {outs, rd[15:0]}, 32'h00FF_0041);
        print_verdict;
    end
endmodule
